// file: rtl/pmco_option_regs.sv
// option and status register bank with its small control side
`timescale 1ns/1ps
`include "pmco_defines.svh"

module pmco_option_regs #(
    parameter int LIMIT_STEP_CYCLES =
        (`PMCO_LIMIT_STEP_PS + `PMCO_CLK_PERIOD_PS - 1) / `PMCO_CLK_PERIOD_PS
) (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire pmco_pkg::pmco_byte_t regAddr,
    input  wire pmco_pkg::pmco_byte_t regWrData,
    input  wire logic               regWrEn,
    input  wire logic               regRdEn,
    output pmco_pkg::pmco_byte_t    regRdData,
    output logic                    regRdValid,
    input  wire logic               enablePin,
    input  wire logic               enableRegisterOne,
    input  wire logic               ch3OverCurrent,
    input  wire pmco_pkg::pmco_flags_t shortEvents,
    output pmco_pkg::pmco_delay_t   ch3LimitDelay,
    output logic                    ch3LimitTrip,
    output pmco_pkg::pmco_sel_t     ch4SlopeSelect,
    output pmco_pkg::pmco_sel_t     ch3RampSelect,
    output pmco_pkg::pmco_sel_t     ch2SlopeSelect,
    output pmco_pkg::pmco_sel_t     ch1SlopeSelect,
    output pmco_pkg::pmco_sel_t     ch3FilterComp,
    output logic                    ch3ExtTransistorLimit,
    output logic                    loadSwitchOneOn,
    output logic                    loadSwitchOneLimitEn,
    output pmco_pkg::pmco_sel_t     ldo2VoltageSelect,
    output logic                    powerGoodPushPull,
    output pmco_pkg::pmco_skip_t    pulseSkipEn,
    output pmco_pkg::pmco_sel_t     ch1TransitionThreshold,
    output logic                    ch1BuckOnly,
    output pmco_pkg::pmco_sel_t     ch2LfPoleSelect,
    output pmco_pkg::pmco_sel_t     ch2HfGainSelect,
    output logic                    deviceShutdown
);
    import pmco_pkg::*;

    localparam int STEP_W = $clog2(LIMIT_STEP_CYCLES + 1);

    // register file
    pmco_byte_t  cs3Delay_r;
    pmco_byte_t  cs3Delay_nxt;
    pmco_byte_t  unusedLoc_r;
    pmco_byte_t  unusedLoc_nxt;
    pmco_byte_t  slope_r;
    pmco_byte_t  slope_nxt;
    pmco_byte_t  ch3Zero_r;
    pmco_byte_t  ch3Zero_nxt;
    pmco_byte_t  misc_r;
    pmco_byte_t  misc_nxt;
    pmco_byte_t  softRstKey_r;
    pmco_byte_t  softRstKey_nxt;
    pmco_flags_t shorts_r;
    pmco_flags_t shorts_nxt;
    pmco_byte_t  bbOpt_r;
    pmco_byte_t  bbOpt_nxt;
    pmco_byte_t  channel12_compensation_r;
    pmco_byte_t  channel12_compensation_nxt;
    pmco_byte_t  rdData_r;
    pmco_byte_t  rdData_nxt;
    logic        rdValid_r;
    logic        rdValid_nxt;
    logic        softRst;
    logic        limitEn_r;
    logic        limitEn_nxt;

    // pin synchronisers: bit 9 enable, bit 8 overcurrent, 7:0 short lines
    logic [9:0]  syncA_r;
    logic [9:0]  syncB_r;
    logic [9:0]  syncC_r;
    logic [9:0]  pinLvl_r;
    logic [9:0]  pinLvl_nxt;

    // control side
    logic [STEP_W-1:0] prescale_r;
    logic [STEP_W-1:0] prescale_nxt;
    pmco_delay_t       steps_r;
    pmco_delay_t       steps_nxt;
    logic              trip_r;
    logic              trip_nxt;
    logic              shutdown_r;
    logic              shutdown_nxt;
    logic              enPrev_r;
    logic              enPrev_nxt;
    logic              ls1On_r;
    logic              ls1On_nxt;

    function automatic logic hit(input pmco_byte_t a, input pmco_byte_t b);
        hit = (a == b);
    endfunction : hit

    // masked write keeps undefined bits at zero
    function automatic pmco_byte_t wrField(input pmco_byte_t d,
                                           input pmco_byte_t m);
        wrField = d & m;
    endfunction : wrField

    assign softRst = regWrEn && hit(regAddr, `PMCO_ADDR_SOFT_RST) &&
                     (regWrData == `PMCO_SOFT_RST_KEY);

    // register write path
    always_comb begin
        cs3Delay_nxt   = cs3Delay_r;
        unusedLoc_nxt  = unusedLoc_r;
        slope_nxt      = slope_r;
        ch3Zero_nxt    = ch3Zero_r;
        misc_nxt       = misc_r;
        softRstKey_nxt = softRstKey_r;
        bbOpt_nxt      = bbOpt_r;
        channel12_compensation_nxt      = channel12_compensation_r;
        if (softRst) begin
            // key never reads back: the reset returns it to zero too
            cs3Delay_nxt   = `PMCO_DEF_CS3_DELAY;
            unusedLoc_nxt  = `PMCO_DEF_UNUSED;
            slope_nxt      = `PMCO_DEF_SLOPE;
            ch3Zero_nxt    = `PMCO_DEF_CH3_ZERO;
            misc_nxt       = `PMCO_DEF_MISC;
            softRstKey_nxt = `PMCO_DEF_SOFT_RST;
            bbOpt_nxt      = `PMCO_DEF_BUCK_BOOST_OPTIONS;
            channel12_compensation_nxt      = `PMCO_DEF_CHANNEL12_COMPENSATION;
        end else if (regWrEn) begin
            unique case (regAddr)
                `PMCO_ADDR_CS3_DELAY: begin
                    cs3Delay_nxt = wrField(regWrData,
                                           `PMCO_MASK_CS3_DELAY);
                end
                `PMCO_ADDR_UNUSED: begin
                    unusedLoc_nxt = wrField(regWrData,
                                            `PMCO_MASK_UNUSED);
                end
                `PMCO_ADDR_SLOPE: begin
                    slope_nxt = wrField(regWrData,
                                        `PMCO_MASK_SLOPE);
                end
                `PMCO_ADDR_CH3_ZERO: begin
                    ch3Zero_nxt = wrField(regWrData,
                                          `PMCO_MASK_CH3_ZERO);
                end
                `PMCO_ADDR_MISC: begin
                    misc_nxt = wrField(regWrData,
                                       `PMCO_MASK_MISC);
                end
                `PMCO_ADDR_SOFT_RST: begin
                    softRstKey_nxt = wrField(regWrData,
                                             `PMCO_MASK_SOFT_RST);
                end
                `PMCO_ADDR_BUCK_BOOST_OPTIONS: begin
                    bbOpt_nxt = wrField(regWrData,
                                        `PMCO_MASK_BUCK_BOOST_OPTIONS);
                end
                `PMCO_ADDR_CHANNEL12_COMPENSATION: begin
                    channel12_compensation_nxt = wrField(regWrData,
                                        `PMCO_MASK_CHANNEL12_COMPENSATION);
                end
                // flags and unmapped addresses take no write
                default: begin
                    cs3Delay_nxt = cs3Delay_r;
                end
            endcase
        end
        // own flop so the limit enable output is not a gate after a flop
        limitEn_nxt = !misc_nxt[`PMCO_BIT_LS1_FORCE];
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cs3Delay_r   <= `PMCO_DEF_CS3_DELAY;
            unusedLoc_r  <= `PMCO_DEF_UNUSED;
            slope_r      <= `PMCO_DEF_SLOPE;
            ch3Zero_r    <= `PMCO_DEF_CH3_ZERO;
            misc_r       <= `PMCO_DEF_MISC;
            softRstKey_r <= `PMCO_DEF_SOFT_RST;
            bbOpt_r      <= `PMCO_DEF_BUCK_BOOST_OPTIONS;
            channel12_compensation_r      <= `PMCO_DEF_CHANNEL12_COMPENSATION;
            limitEn_r    <= 1'b1; // force bit clear by default
        end else begin
            cs3Delay_r   <= cs3Delay_nxt;
            unusedLoc_r  <= unusedLoc_nxt;
            slope_r      <= slope_nxt;
            ch3Zero_r    <= ch3Zero_nxt;
            misc_r       <= misc_nxt;
            softRstKey_r <= softRstKey_nxt;
            bbOpt_r      <= bbOpt_nxt;
            channel12_compensation_r      <= channel12_compensation_nxt;
            limitEn_r    <= limitEn_nxt;
        end
    end

    // read path, answer one cycle after the request
    always_comb begin
        rdValid_nxt = regRdEn;
        rdData_nxt  = 8'h00;
        if (regRdEn) begin
            unique case (regAddr)
                `PMCO_ADDR_CS3_DELAY: rdData_nxt = cs3Delay_r;
                `PMCO_ADDR_UNUSED:    rdData_nxt = unusedLoc_r;
                `PMCO_ADDR_SLOPE:     rdData_nxt = slope_r;
                `PMCO_ADDR_CH3_ZERO:  rdData_nxt = ch3Zero_r;
                `PMCO_ADDR_MISC:      rdData_nxt = misc_r;
                `PMCO_ADDR_SOFT_RST:  rdData_nxt = softRstKey_r;
                `PMCO_ADDR_SHORTS:    rdData_nxt = shorts_r;
                `PMCO_ADDR_BUCK_BOOST_OPTIONS:    rdData_nxt = bbOpt_r;
                `PMCO_ADDR_CHANNEL12_COMPENSATION:     rdData_nxt = channel12_compensation_r;
                default:              rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_r  <= 8'h00;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r  <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    // pin inputs: three stages, a change counts when stages two and three agree
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pinLvl_nxt[i] = (syncB_r[i] == syncC_r[i]) ? syncC_r[i]
                                                        : pinLvl_r[i];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_r  <= 10'h000;
            syncB_r  <= 10'h000;
            syncC_r  <= 10'h000;
            pinLvl_r <= 10'h000;
        end else begin
            syncA_r  <= {enablePin, ch3OverCurrent, shortEvents};
            syncB_r  <= syncA_r;
            syncC_r  <= syncB_r;
            pinLvl_r <= pinLvl_nxt;
        end
    end

    // sticky short flags; a short seen in the soft reset cycle still sets
    always_comb begin
        shorts_nxt = (softRst ? `PMCO_DEF_SHORTS : shorts_r) |
                     pinLvl_r[7:0];
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            shorts_r <= `PMCO_DEF_SHORTS;
        end else begin
            shorts_r <= shorts_nxt;
        end
    end

    // ch3 limit delay: step counter scaled by the prescaler
    always_comb begin
        prescale_nxt = prescale_r;
        steps_nxt    = steps_r;
        trip_nxt     = trip_r;
        if (!pinLvl_r[8] || softRst) begin
            prescale_nxt = '0;
            steps_nxt    = 6'h00;
            trip_nxt     = 1'b0;
        end else if (cs3Delay_r[5:0] == 6'h00) begin
            trip_nxt = 1'b1;
        end else if (!trip_r) begin
            if (prescale_r == STEP_W'(LIMIT_STEP_CYCLES - 1)) begin
                prescale_nxt = '0;
                steps_nxt    = steps_r + 6'h01;
                // at or past: a code shortened mid-count still trips
                trip_nxt     = (steps_r + 6'h01) >= cs3Delay_r[5:0];
            end else begin
                prescale_nxt = prescale_r + STEP_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale_r <= '0;
            steps_r    <= 6'h00;
            trip_r     <= 1'b0;
        end else begin
            prescale_r <= prescale_nxt;
            steps_r    <= steps_nxt;
            trip_r     <= trip_nxt;
        end
    end

    // shutdown holds until the enable pin rises again, so a pin left high
    // cannot restart the regulators behind the host's back
    always_comb begin
        enPrev_nxt   = pinLvl_r[9];
        shutdown_nxt = shutdown_r;
        if (softRst) begin
            shutdown_nxt = 1'b1;
        end else if (pinLvl_r[9] && !enPrev_r) begin
            shutdown_nxt = 1'b0;
        end
        if (misc_r[`PMCO_BIT_LS1_FORCE]) begin
            ls1On_nxt = enableRegisterOne;
        end else begin
            ls1On_nxt = enableRegisterOne && pinLvl_r[9] && !shutdown_r;
        end
        if (softRst) begin
            ls1On_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enPrev_r   <= 1'b0;
            shutdown_r <= 1'b0;
            ls1On_r    <= 1'b0;
        end else begin
            enPrev_r   <= enPrev_nxt;
            shutdown_r <= shutdown_nxt;
            ls1On_r    <= ls1On_nxt;
        end
    end

    // field outputs come straight from the register flops
    assign regRdData              = rdData_r;
    assign regRdValid             = rdValid_r;
    assign ch3LimitDelay          = cs3Delay_r[5:0];
    assign ch3LimitTrip           = trip_r;
    assign ch4SlopeSelect         = slope_r[7:6];
    assign ch3RampSelect          = slope_r[5:4];
    assign ch2SlopeSelect         = slope_r[3:2];
    assign ch1SlopeSelect         = slope_r[1:0];
    assign ch3FilterComp          = ch3Zero_r[6:5];
    assign ch3ExtTransistorLimit  = ch3Zero_r[`PMCO_BIT_EXT_LIMIT];
    assign loadSwitchOneOn        = ls1On_r;
    assign loadSwitchOneLimitEn   = limitEn_r;
    assign ldo2VoltageSelect      = misc_r[5:4];
    assign powerGoodPushPull      = misc_r[`PMCO_BIT_PG_PUSHPULL];
    assign pulseSkipEn            = {misc_r[2:0],
                                     bbOpt_r[`PMCO_BIT_CH1_SKIP]};
    assign ch1TransitionThreshold = bbOpt_r[3:2];
    assign ch1BuckOnly            = bbOpt_r[`PMCO_BIT_BUCK_ONLY];
    assign ch2LfPoleSelect        = channel12_compensation_r[7:6];
    assign ch2HfGainSelect        = channel12_compensation_r[5:4];
    assign deviceShutdown         = shutdown_r;

endmodule : pmco_option_regs

// file: include/pmco_defines.svh
// offsets, field positions, defaults and timing counts of the option bank
`ifndef PMCO_DEFINES_SVH
`define PMCO_DEFINES_SVH

`define PMCO_ADDR_CS3_DELAY   8'h1e
`define PMCO_ADDR_UNUSED      8'h1f
`define PMCO_ADDR_SLOPE       8'h20
`define PMCO_ADDR_CH3_ZERO    8'h21
`define PMCO_ADDR_MISC        8'h22
`define PMCO_ADDR_SOFT_RST    8'h23
`define PMCO_ADDR_SHORTS      8'h30
`define PMCO_ADDR_BUCK_BOOST_OPTIONS      8'h31
`define PMCO_ADDR_CHANNEL12_COMPENSATION       8'h32

`define PMCO_MASK_CS3_DELAY   8'h3f
`define PMCO_MASK_UNUSED      8'hff
`define PMCO_MASK_SLOPE       8'hff
`define PMCO_MASK_CH3_ZERO    8'h70
`define PMCO_MASK_MISC        8'h7f
`define PMCO_MASK_SOFT_RST    8'hff
`define PMCO_MASK_BUCK_BOOST_OPTIONS      8'h0f
`define PMCO_MASK_CHANNEL12_COMPENSATION       8'hf0

`define PMCO_DEF_CS3_DELAY    8'h05
`define PMCO_DEF_UNUSED       8'h00
`define PMCO_DEF_SLOPE        8'h04
`define PMCO_DEF_CH3_ZERO     8'h40
`define PMCO_DEF_MISC         8'h07
`define PMCO_DEF_SOFT_RST     8'h00
`define PMCO_DEF_SHORTS       8'h00
`define PMCO_DEF_BUCK_BOOST_OPTIONS       8'h02
`define PMCO_DEF_CHANNEL12_COMPENSATION        8'h00

`define PMCO_SOFT_RST_KEY     8'h55

`define PMCO_BIT_LS1_FORCE    6
`define PMCO_BIT_PG_PUSHPULL  3
`define PMCO_BIT_EXT_LIMIT    4
`define PMCO_BIT_CH1_SKIP     1
`define PMCO_BIT_BUCK_ONLY    0

`define PMCO_CLK_PERIOD_PS    10000
`define PMCO_LIMIT_STEP_PS    1050000000

`endif

// file: include/pmco_pkg.sv
// types shared by the option register bank
package pmco_pkg;
    typedef logic [7:0] pmco_byte_t;
    typedef logic [5:0] pmco_delay_t;
    typedef logic [1:0] pmco_sel_t;
    typedef logic [3:0] pmco_skip_t;
    typedef logic [7:0] pmco_flags_t;
endpackage : pmco_pkg

// file: bench/pmco_option_regs_chk_assertions.sv
// port checks on the option register bank
`timescale 1ns/1ps
module pmco_option_regs_chk #(
    parameter int LIMIT_STEP_CYCLES = 4
) (
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire pmco_pkg::pmco_byte_t  regAddr,
    input wire pmco_pkg::pmco_byte_t  regWrData,
    input wire logic                  regWrEn,
    input wire logic                  regRdEn,
    input wire pmco_pkg::pmco_byte_t  regRdData,
    input wire logic                  regRdValid,
    input wire logic                  enableRegisterOne,
    input wire pmco_pkg::pmco_delay_t ch3LimitDelay,
    input wire pmco_pkg::pmco_sel_t   ch2SlopeSelect,
    input wire pmco_pkg::pmco_sel_t   ch3FilterComp,
    input wire logic                  ch3ExtTransistorLimit,
    input wire logic                  loadSwitchOneOn,
    input wire logic                  loadSwitchOneLimitEn,
    input wire logic                  powerGoodPushPull,
    input wire pmco_pkg::pmco_skip_t  pulseSkipEn,
    input wire pmco_pkg::pmco_sel_t   ch1TransitionThreshold,
    input wire logic                  ch1BuckOnly,
    input wire pmco_pkg::pmco_sel_t   ch2LfPoleSelect,
    input wire pmco_pkg::pmco_sel_t   ch2HfGainSelect,
    input wire logic                  deviceShutdown
);
    import pmco_pkg::*;
    pmco_byte_t wa_r;
    pmco_byte_t wd_r;
    logic       wh_r;
    logic       key_r;
    // previous cycle's strobe lines, so field checks see their cause
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wa_r  <= 8'h00;
            wd_r  <= 8'h00;
            wh_r  <= 1'b0;
            key_r <= 1'b0;
        end else begin
            wa_r  <= regAddr;
            wd_r  <= regWrData;
            wh_r  <= regWrEn;
            key_r <= regWrEn && regAddr == 8'h23 && regWrData == 8'h55;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_rd_unmapped: assert property (regRdEn && !(regAddr inside
        {[8'h1e:8'h23], [8'h30:8'h32]}) |=> regRdValid && regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_rd_idle: assert property (!$past(regRdEn) |-> !regRdValid
        && regRdData == 8'h00) else $error("read answer without request");
    chk_key_defaults: assert property (key_r |-> deviceShutdown
        && !loadSwitchOneOn && ch3LimitDelay == 6'h05 && pulseSkipEn == 4'hf
        && ch3FilterComp == 2'h2 && ch2SlopeSelect == 2'h1)
        else $error("soft reset left state behind");
    chk_delay_write: assert property (wh_r && wa_r == 8'h1e
        |-> ch3LimitDelay == wd_r[5:0]) else $error("delay field wrong");
    chk_slope_write: assert property (wh_r && wa_r == 8'h20
        |-> ch2SlopeSelect == wd_r[3:2]) else $error("slope field wrong");
    chk_fet_write: assert property (wh_r && wa_r == 8'h21
        |-> ch3ExtTransistorLimit == wd_r[4] && ch3FilterComp == wd_r[6:5])
        else $error("ch3 zero fields wrong");
    chk_force_write: assert property (wh_r && wa_r == 8'h22
        |-> loadSwitchOneLimitEn == !wd_r[6]) else $error("limit enable wrong");
    chk_skip_write: assert property (wh_r && wa_r == 8'h22
        |-> pulseSkipEn[3:1] == wd_r[2:0] && powerGoodPushPull == wd_r[3])
        else $error("skip or pg field wrong");
    chk_force_follow: assert property (!$past(loadSwitchOneLimitEn)
        && !key_r |-> loadSwitchOneOn == $past(enableRegisterOne))
        else $error("forced switch ignores enable bit");
    chk_bb_write: assert property (wh_r && wa_r == 8'h31
        |-> ch1TransitionThreshold == wd_r[3:2] && ch1BuckOnly == wd_r[0]
        && pulseSkipEn[0] == wd_r[1]) else $error("bb fields wrong");
    chk_comp_write: assert property (wh_r && wa_r == 8'h32
        |-> ch2LfPoleSelect == wd_r[7:6] && ch2HfGainSelect == wd_r[5:4])
        else $error("comp fields wrong");
    cov_soft_reset: cover property (key_r);
    cov_forced_on: cover property (!loadSwitchOneLimitEn && loadSwitchOneOn);
    cov_read_data: cover property (regRdValid && regRdData != 8'h00);
endmodule : pmco_option_regs_chk
bind pmco_option_regs pmco_option_regs_chk #(
    .LIMIT_STEP_CYCLES(LIMIT_STEP_CYCLES)
) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .enableRegisterOne(enableRegisterOne), .ch3LimitDelay(ch3LimitDelay),
    .ch2SlopeSelect(ch2SlopeSelect), .ch3FilterComp(ch3FilterComp),
    .ch3ExtTransistorLimit(ch3ExtTransistorLimit),
    .loadSwitchOneOn(loadSwitchOneOn),
    .loadSwitchOneLimitEn(loadSwitchOneLimitEn),
    .powerGoodPushPull(powerGoodPushPull), .pulseSkipEn(pulseSkipEn),
    .ch1TransitionThreshold(ch1TransitionThreshold),
    .ch1BuckOnly(ch1BuckOnly), .ch2LfPoleSelect(ch2LfPoleSelect),
    .ch2HfGainSelect(ch2HfGainSelect), .deviceShutdown(deviceShutdown)
);

// file: bench/pmco_host_model.sv
// host side of the register strobe port
`timescale 1ns/1ps
module pmco_host_model (
    input  wire logic                 mclk,
    output pmco_pkg::pmco_byte_t      regAddr,
    output pmco_pkg::pmco_byte_t      regWrData,
    output logic                      regWrEn,
    output logic                      regRdEn,
    input  wire pmco_pkg::pmco_byte_t regRdData,
    input  wire logic                 regRdValid
);
    import pmco_pkg::*;
    initial begin
        regAddr   = 8'h00;
        regWrData = 8'h00;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
    end
    // released lines are inverted so stale values never look current
    task automatic wr(input pmco_byte_t a, input pmco_byte_t d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge mclk);
        regWrEn   <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input pmco_byte_t a, output pmco_byte_t d,
                      output logic v);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        @(posedge mclk);
        d = regRdData;
        v = regRdValid;
    endtask : rd
    task automatic softReset();
        wr(8'h23, 8'h55);
    endtask : softReset
endmodule : pmco_host_model

// file: bench/pmic_channel_option_registers_tb.sv
// self-checking bench for the option register bank
`timescale 1ns/1ps
module pmic_channel_option_registers_tb;
    import pmco_pkg::*;
    localparam int STEP = 4;
    localparam pmco_byte_t ADDRS [0:8] = '{8'h1e, 8'h1f, 8'h20, 8'h21,
        8'h22, 8'h23, 8'h30, 8'h31, 8'h32};
    localparam pmco_byte_t DEFS [0:8] = '{8'h05, 8'h00, 8'h04, 8'h40,
        8'h07, 8'h00, 8'h00, 8'h02, 8'h00};
    localparam pmco_byte_t MASKS [0:8] = '{8'h3f, 8'hff, 8'hff, 8'h70,
        8'h7f, 8'hff, 8'h00, 8'h0f, 8'hf0};
    logic        mclk, sys_rst, enablePin, enableRegisterOne, ch3OverCurrent;
    logic        regWrEn, regRdEn, regRdValid, ch3LimitTrip, v;
    logic        ch3ExtTransistorLimit, loadSwitchOneOn, loadSwitchOneLimitEn;
    logic        powerGoodPushPull, ch1BuckOnly, deviceShutdown;
    pmco_byte_t  regAddr, regWrData, regRdData, rdVal, d;
    pmco_byte_t  shadow [0:8];
    pmco_flags_t shortEvents;
    pmco_delay_t ch3LimitDelay;
    pmco_skip_t  pulseSkipEn;
    pmco_sel_t   ch4SlopeSelect, ch3RampSelect, ch2SlopeSelect, ch1SlopeSelect;
    pmco_sel_t   ch3FilterComp, ldo2VoltageSelect, ch1TransitionThreshold;
    pmco_sel_t   ch2LfPoleSelect, ch2HfGainSelect;
    logic [31:0] seed = 32'h4d;
    logic [31:0] r;
    int          failures = 0;
    int          checks_done = 0;
    int          idx, c;
    pmco_option_regs #(.LIMIT_STEP_CYCLES(STEP)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .enablePin(enablePin), .enableRegisterOne(enableRegisterOne),
        .ch3OverCurrent(ch3OverCurrent), .shortEvents(shortEvents),
        .ch3LimitDelay(ch3LimitDelay), .ch3LimitTrip(ch3LimitTrip),
        .ch4SlopeSelect(ch4SlopeSelect), .ch3RampSelect(ch3RampSelect),
        .ch2SlopeSelect(ch2SlopeSelect), .ch1SlopeSelect(ch1SlopeSelect),
        .ch3FilterComp(ch3FilterComp),
        .ch3ExtTransistorLimit(ch3ExtTransistorLimit),
        .loadSwitchOneOn(loadSwitchOneOn),
        .loadSwitchOneLimitEn(loadSwitchOneLimitEn),
        .ldo2VoltageSelect(ldo2VoltageSelect),
        .powerGoodPushPull(powerGoodPushPull), .pulseSkipEn(pulseSkipEn),
        .ch1TransitionThreshold(ch1TransitionThreshold),
        .ch1BuckOnly(ch1BuckOnly), .ch2LfPoleSelect(ch2LfPoleSelect),
        .ch2HfGainSelect(ch2HfGainSelect), .deviceShutdown(deviceShutdown));
    pmco_host_model host (
        .mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nextRand
    // every field output as the shadow copy says it should be
    function automatic logic [31:0] expOuts();
        return {shadow[0][5:0], shadow[2], shadow[3][6:4], ~shadow[4][6],
            shadow[4][5:0], shadow[7][1], shadow[7][3:2], shadow[7][0],
            shadow[8][7:4]};
    endfunction : expOuts
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmpOuts();
        cmp({ch3LimitDelay, ch4SlopeSelect, ch3RampSelect, ch2SlopeSelect,
            ch1SlopeSelect, ch3FilterComp, ch3ExtTransistorLimit,
            loadSwitchOneLimitEn, ldo2VoltageSelect, powerGoodPushPull,
            pulseSkipEn, ch1TransitionThreshold, ch1BuckOnly,
            ch2LfPoleSelect, ch2HfGainSelect}, expOuts());
    endtask : cmpOuts
    task automatic readAll();
        for (int i = 0; i < 9; i++) begin
            host.rd(ADDRS[i], rdVal, v);
            cmp({23'h0, v, rdVal}, {24'h1, shadow[i]});
        end
        host.rd(8'h24, rdVal, v);
        cmp({23'h0, v, rdVal}, 32'h100);
        cmpOuts();
    endtask : readAll
    // counts cycles until the trip output reaches lvl; a hang ends the run
    task automatic waitTrip(input logic lvl);
        c = 0;
        while (ch3LimitTrip !== lvl && c < 600) begin
            @(posedge mclk);
            c++;
        end
        if (c >= 600) begin
            failures++;
            summarize();
        end
    endtask : waitTrip
    initial begin
        sys_rst = 1'b1;
        enablePin = 1'b1;
        enableRegisterOne = 1'b0;
        ch3OverCurrent = 1'b0;
        shortEvents = 8'h00;
        shadow = DEFS;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        readAll();
        $display("test defaults done");
        for (int n = 0; n < 80; n++) begin
            r = nextRand();
            idx = r[31:8] % 9;
            d = r[7:0];
            if (idx == 5 && d == 8'h55) d = 8'h54;
            host.wr(ADDRS[idx], d);
            if (idx != 6) shadow[idx] = d & MASKS[idx];
            host.rd(ADDRS[idx], rdVal, v);
            cmp({24'h0, rdVal}, {24'h0, shadow[idx]});
            cmpOuts();
            host.rd({2'b01, r[13:8]}, rdVal, v);
            cmp({24'h0, rdVal}, 32'h0);
        end
        $display("test random done");
        enablePin <= 1'b0;
        enableRegisterOne <= 1'b1;
        host.wr(8'h22, 8'h47);
        repeat (6) @(posedge mclk);
        cmp({31'h0, loadSwitchOneOn}, 32'h1);
        host.wr(8'h22, 8'h07);
        repeat (2) @(posedge mclk);
        cmp({31'h0, loadSwitchOneOn}, 32'h0);
        enablePin <= 1'b1;
        repeat (8) @(posedge mclk);
        cmp({31'h0, loadSwitchOneOn}, 32'h1);
        $display("test load switch done");
        shortEvents <= 8'h81;
        repeat (6) @(posedge mclk);
        shortEvents <= 8'h00;
        host.wr(8'h30, 8'h00);
        repeat (6) @(posedge mclk);
        host.rd(8'h30, rdVal, v);
        cmp({24'h0, rdVal}, 32'h81);
        host.softReset();
        shadow = DEFS;
        readAll();
        cmp({30'h0, deviceShutdown, loadSwitchOneOn}, 32'h2);
        enablePin <= 1'b0;
        repeat (6) @(posedge mclk);
        cmp({31'h0, deviceShutdown}, 32'h1);
        enablePin <= 1'b1;
        repeat (6) @(posedge mclk);
        cmp({31'h0, deviceShutdown}, 32'h0);
        $display("test soft reset done");
        for (int k = 0; k < 3; k++) begin
            idx = (k == 2) ? 3 : k;
            host.wr(8'h1e, idx[7:0]);
            ch3OverCurrent <= 1'b1;
            waitTrip(1'b1);
            cmp({31'h0, c >= idx * STEP && c <= idx * STEP + 8},
                32'h1);
            ch3OverCurrent <= 1'b0;
            waitTrip(1'b0);
        end
        $display("test limit delay done");
        summarize();
    end
endmodule : pmic_channel_option_registers_tb
